// file: src/rtx_exec.sv
// decode and execute unit for register transfers and the incrementing ram exchange
// Behaviour
// - decode 101110jjjj as incrementing ram exchange
// - exchange accumulator with addressed ram nibble
// - column pointer becomes column xor immediate
// - row pointer increments, wrapping modulo sixteen
// - skip next instruction when row wraps
// - otherwise no skip, carry untouched
// - 0x01E copies b into accumulator
// - 0x00E copies accumulator into b
// - 0x01F copies row pointer into accumulator
// - 0x00C copies accumulator into row pointer
// - 0x01A packs b and accumulator into e
// - 0x029 copies accumulator low bits to port
// - 0x051 port register to accumulator, top cleared
// - 0x053 file pointer to accumulator, top cleared
// - 0x052 copies column pointer into accumulator
// - 0x050 stack pointer to accumulator, top cleared
// - 0x02A unpacks e into b and accumulator
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module rtx_exec
  import rtx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire rtx_instr_t instr,
  input wire logic [1:0] file_ptr,
  input wire logic [2:0] stack_ptr,
  input wire logic [3:0] ram_rdata,
  output rtx_ram_req_t ram_req,
  output logic skip_req,
  output logic exec_done,
  output rtx_regs_t regs,
  input wire rtx_wb_req_t wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // opcode decode for this instruction group
  function automatic rtx_op_t decode_op(input logic [9:0] code);
    rtx_op_t op;
    op = RTX_OP_NONE;
    if (code[INSTR_W-1:XCHG_PFX_LSB] == XCHG_INC_PFX) begin
      op = RTX_OP_SWAP_ACC_MEM_INC_ROW;
    end else begin
      unique case (code)
        OPC_COPY_B_TO_ACC: op = RTX_OP_COPY_B_TO_ACC;
        OPC_COPY_ACC_TO_B: op = RTX_OP_COPY_ACC_TO_B;
        OPC_COPY_ROW_TO_ACC: op = RTX_OP_COPY_ROW_TO_ACC;
        OPC_COPY_ACC_TO_ROW: op = RTX_OP_COPY_ACC_TO_ROW;
        OPC_PACK_B_ACC_INTO_E: op = RTX_OP_PACK_B_ACC_INTO_E;
        OPC_UNPACK_E_TO_B_ACC: op = RTX_OP_UNPACK_E_TO_B_ACC;
        OPC_COPY_ACC_TO_PORT_REG: op = RTX_OP_COPY_ACC_TO_PORT_REG;
        OPC_COPY_PORT_REG_TO_ACC: op = RTX_OP_COPY_PORT_REG_TO_ACC;
        OPC_COPY_FILE_PTR_TO_ACC: op = RTX_OP_COPY_FILE_PTR_TO_ACC;
        OPC_COPY_COL_TO_ACC: op = RTX_OP_COPY_COL_TO_ACC;
        OPC_COPY_STACK_PTR_TO_ACC: op = RTX_OP_COPY_STACK_PTR_TO_ACC;
        default: op = RTX_OP_NONE;
      endcase
    end
    return op;
  endfunction

  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic [3:0] b_q;
  logic [3:0] b_d;
  logic [3:0] col_q;
  logic [3:0] col_d;
  logic [3:0] row_q;
  logic [3:0] row_d;
  logic [7:0] e_q;
  logic [7:0] e_d;
  logic [2:0] port_q;
  logic [2:0] port_d;
  logic skip_q;
  logic skip_d;
  logic done_q;
  logic exec_en_q;
  logic stat_skip_q;
  logic stat_exec_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [3:0] imm;
  logic [3:0] row_inc;
  logic fire;
  logic wb_hit;
  logic wb_wr;
  logic wr_ctrl;
  logic wr_status;
  rtx_op_t op;

  assign imm = instr.code[IMM_LSB +: IMM_W];
  // row pointer plus one, four-bit wrap
  assign row_inc = row_q + ROW_ONE;
  // execution is gated by the software enable, on from reset; every decoded op finishes in this one cycle
  assign fire = ce && exec_en_q && instr.valid;
  assign op = fire ? decode_op(instr.code) : RTX_OP_NONE;

  // next-state selection for the working registers
  always_comb begin
    acc_d = acc_q;
    b_d = b_q;
    col_d = col_q;
    row_d = row_q;
    e_d = e_q;
    port_d = port_q;
    skip_d = 1'b0;
    unique case (op)
      RTX_OP_SWAP_ACC_MEM_INC_ROW: begin
        // accumulator takes the old ram nibble
        acc_d = ram_rdata;
        col_d = col_q ^ imm;
        row_d = row_inc;
        // no skip for a nonzero row
        skip_d = (row_inc == ROW_WRAP);
      end
      RTX_OP_COPY_B_TO_ACC: begin
        acc_d = b_q;
      end
      RTX_OP_COPY_ACC_TO_B: begin
        b_d = acc_q;
      end
      RTX_OP_COPY_ROW_TO_ACC: begin
        acc_d = row_q;
      end
      RTX_OP_COPY_ACC_TO_ROW: begin
        row_d = acc_q;
      end
      RTX_OP_PACK_B_ACC_INTO_E: begin
        e_d = {b_q, acc_q};
      end
      RTX_OP_UNPACK_E_TO_B_ACC: begin
        b_d = e_q[E_W-1:NIB_W];
        acc_d = e_q[NIB_W-1:0];
      end
      RTX_OP_COPY_ACC_TO_PORT_REG: begin
        port_d = acc_q[PORT_W-1:0];
      end
      RTX_OP_COPY_PORT_REG_TO_ACC: begin
        acc_d = {1'b0, port_q};
      end
      RTX_OP_COPY_FILE_PTR_TO_ACC: begin
        acc_d = {2'b00, file_ptr};
      end
      RTX_OP_COPY_COL_TO_ACC: begin
        acc_d = col_q;
      end
      RTX_OP_COPY_STACK_PTR_TO_ACC: begin
        acc_d = {1'b0, stack_ptr};
      end
      RTX_OP_NONE: begin
        skip_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_q <= NIB_RST;
    end else if (ce) begin
      acc_q <= acc_d;
    end
  end

  // b register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      b_q <= NIB_RST;
    end else if (ce) begin
      b_q <= b_d;
    end
  end

  // column pointer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      col_q <= NIB_RST;
    end else if (ce) begin
      col_q <= col_d;
    end
  end

  // row pointer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      row_q <= NIB_RST;
    end else if (ce) begin
      row_q <= row_d;
    end
  end

  // e register, both nibbles at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      e_q <= E_RST;
    end else if (ce) begin
      e_q <= e_d;
    end
  end

  // three-bit port register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_q <= PORT_RST;
    end else if (ce) begin
      port_q <= port_d;
    end
  end

  // registered skip pulse after the executing edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else if (ce) begin
      skip_q <= skip_d;
    end
  end

  // completion strobe, registered at the executing edge together with the registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= (op != RTX_OP_NONE);
    end
  end

  // memory side of the exchange writes the old accumulator
  assign ram_req.we = (op == RTX_OP_SWAP_ACC_MEM_INC_ROW);
  assign ram_req.wdata = acc_q;
  assign ram_req.addr = {file_ptr, col_q, row_q};

  assign skip_req = skip_q;
  assign exec_done = done_q;
  assign regs.acc = acc_q;
  assign regs.b = b_q;
  assign regs.col = col_q;
  assign regs.row = row_q;
  assign regs.e = e_q;
  assign regs.port_reg = port_q;

  // wishbone slave: one-cycle registered acknowledge
  assign wb_hit = wb_req.cyc && wb_req.stb && !ack_q;
  // writes land at the edge where the master samples ack
  assign wb_wr = wb_req.cyc && wb_req.stb && ack_q && wb_req.we && wb_req.sel[0];
  assign wr_ctrl = wb_wr && (wb_req.adr == OFS_CTRL);
  assign wr_status = wb_wr && (wb_req.adr == OFS_STATUS);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= wb_hit;
    end
  end

  // control register: execution enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      exec_en_q <= CTRL_EXEC_EN_RST;
    end else if (ce && wr_ctrl) begin
      exec_en_q <= wb_req.dat[CTRL_EXEC_EN_BIT];
    end
  end

  // sticky skip flag, write one to clear; a new event wins over the clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_skip_q <= 1'b0;
    end else if (ce) begin
      if (skip_d) begin
        stat_skip_q <= 1'b1;
      end else if (wr_status && wb_req.dat[STAT_SKIP_BIT]) begin
        stat_skip_q <= 1'b0;
      end
    end
  end

  // sticky executed flag, same clear and priority
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_exec_q <= 1'b0;
    end else if (ce) begin
      if (op != RTX_OP_NONE) begin
        stat_exec_q <= 1'b1;
      end else if (wr_status && wb_req.dat[STAT_EXEC_BIT]) begin
        stat_exec_q <= 1'b0;
      end
    end
  end

  // read data mux; unmapped addresses read zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    unique case (wb_req.adr)
      OFS_CTRL: rdat_d[CTRL_EXEC_EN_BIT] = exec_en_q;
      OFS_STATUS: begin
        rdat_d[STAT_SKIP_BIT] = stat_skip_q;
        rdat_d[STAT_EXEC_BIT] = stat_exec_q;
      end
      OFS_NIBS: begin
        rdat_d[NIBS_ACC_LSB +: NIB_W] = acc_q;
        rdat_d[NIBS_B_LSB +: NIB_W] = b_q;
        rdat_d[NIBS_COL_LSB +: NIB_W] = col_q;
        rdat_d[NIBS_ROW_LSB +: NIB_W] = row_q;
      end
      OFS_EPORT: begin
        rdat_d[EPORT_E_LSB +: E_W] = e_q;
        rdat_d[EPORT_PORT_LSB +: PORT_W] = port_q;
      end
      default: rdat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdat_q <= 32'h0000_0000;
    end else if (ce && wb_hit) begin
      rdat_q <= rdat_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

endmodule

`default_nettype wire

// file: inc/rtx_pkg.sv
// shared constants and types for the register transfer and ram exchange unit
package rtx_pkg;

  // instruction word
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned IMM_LSB = 0;
  localparam int unsigned IMM_W = 4;
  localparam int unsigned XCHG_PFX_LSB = 4;
  localparam logic [5:0] XCHG_INC_PFX = 6'h2E;

  // single-word register transfer codes
  localparam logic [9:0] OPC_COPY_B_TO_ACC = 10'h01E;
  localparam logic [9:0] OPC_COPY_ACC_TO_B = 10'h00E;
  localparam logic [9:0] OPC_COPY_ROW_TO_ACC = 10'h01F;
  localparam logic [9:0] OPC_COPY_ACC_TO_ROW = 10'h00C;
  localparam logic [9:0] OPC_PACK_B_ACC_INTO_E = 10'h01A;
  localparam logic [9:0] OPC_UNPACK_E_TO_B_ACC = 10'h02A;
  localparam logic [9:0] OPC_COPY_ACC_TO_PORT_REG = 10'h029;
  localparam logic [9:0] OPC_COPY_PORT_REG_TO_ACC = 10'h051;
  localparam logic [9:0] OPC_COPY_FILE_PTR_TO_ACC = 10'h053;
  localparam logic [9:0] OPC_COPY_COL_TO_ACC = 10'h052;
  localparam logic [9:0] OPC_COPY_STACK_PTR_TO_ACC = 10'h050;

  // register widths and reset values
  localparam int unsigned NIB_W = 4;
  localparam int unsigned E_W = 8;
  localparam int unsigned PORT_W = 3;
  localparam int unsigned FILE_W = 2;
  localparam int unsigned SP_W = 3;
  localparam int unsigned DP_W = FILE_W + 2 * NIB_W;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [7:0] E_RST = 8'h00;
  localparam logic [2:0] PORT_RST = 3'h0;
  localparam logic [3:0] ROW_ONE = 4'h1;
  localparam logic [3:0] ROW_WRAP = 4'h0;

  // wishbone register map, byte addresses
  localparam int unsigned WB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_NIBS = 8'h08;
  localparam logic [7:0] OFS_EPORT = 8'h0C;
  localparam int unsigned CTRL_EXEC_EN_BIT = 0;
  localparam logic CTRL_EXEC_EN_RST = 1'b1;
  localparam int unsigned STAT_SKIP_BIT = 0;
  localparam int unsigned STAT_EXEC_BIT = 1;
  localparam int unsigned NIBS_ACC_LSB = 0;
  localparam int unsigned NIBS_B_LSB = 4;
  localparam int unsigned NIBS_COL_LSB = 8;
  localparam int unsigned NIBS_ROW_LSB = 12;
  localparam int unsigned EPORT_E_LSB = 0;
  localparam int unsigned EPORT_PORT_LSB = 8;

  typedef enum logic [3:0] {
    RTX_OP_NONE,
    RTX_OP_SWAP_ACC_MEM_INC_ROW,
    RTX_OP_COPY_B_TO_ACC,
    RTX_OP_COPY_ACC_TO_B,
    RTX_OP_COPY_ROW_TO_ACC,
    RTX_OP_COPY_ACC_TO_ROW,
    RTX_OP_PACK_B_ACC_INTO_E,
    RTX_OP_UNPACK_E_TO_B_ACC,
    RTX_OP_COPY_ACC_TO_PORT_REG,
    RTX_OP_COPY_PORT_REG_TO_ACC,
    RTX_OP_COPY_FILE_PTR_TO_ACC,
    RTX_OP_COPY_COL_TO_ACC,
    RTX_OP_COPY_STACK_PTR_TO_ACC
  } rtx_op_t;

  typedef struct packed {
    logic valid;
    logic [9:0] code;
  } rtx_instr_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [3:0] wdata;
    logic we;
  } rtx_ram_req_t;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] b;
    logic [3:0] col;
    logic [3:0] row;
    logic [7:0] e;
    logic [2:0] port_reg;
  } rtx_regs_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } rtx_wb_req_t;

endpackage

// file: tb/rtx_exec_checker.sv
// assertion checker for the exchange and transfer unit
`timescale 1ns/1ns
`default_nettype none
module rtx_exec_checker
  import rtx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire rtx_instr_t instr,
  input wire logic [1:0] file_ptr,
  input wire logic [2:0] stack_ptr,
  input wire logic [3:0] ram_rdata,
  input wire rtx_ram_req_t ram_req,
  input wire logic skip_req,
  input wire logic exec_done,
  input wire rtx_regs_t regs,
  input wire rtx_wb_req_t wb_req,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  logic xchg_q;
  wire logic xchg_now = ce && instr.valid && instr.code[9:4] == XCHG_INC_PFX;
  // remembers that the previous edge offered an exchange
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      xchg_q <= 1'b0;
    end else begin
      xchg_q <= xchg_now;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence xchg_done_s;
    exec_done && xchg_q;
  endsequence
  acc_swap_a: assert property (xchg_done_s |-> regs.acc == $past(ram_rdata))
    else $error("accumulator did not take ram nibble");
  col_xor_a: assert property (xchg_done_s |-> regs.col == ($past(regs.col) ^ $past(instr.code[3:0])))
    else $error("column not xored with immediate");
  row_inc_a: assert property (xchg_done_s |-> regs.row == $past(regs.row) + 4'h1)
    else $error("row not incremented");
  skip_wrap_a: assert property (xchg_done_s |-> skip_req == (regs.row == ROW_WRAP))
    else $error("skip does not follow row wrap");
  skip_cause_a: assert property (skip_req |-> exec_done && (xchg_q || !$past(ce)))
    else $error("skip without exchange");
  ram_write_a: assert property (ram_req.we |-> xchg_now && ram_req.wdata == regs.acc)
    else $error("ram write outside exchange");
  ram_addr_a: assert property (ram_req.addr == {file_ptr, regs.col, regs.row})
    else $error("ram address not from pointers");
  wb_ack_a: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o && ce |=> wb_ack_o ##1 (!wb_ack_o || !$past(ce)))
    else $error("bus ack not a one cycle answer");
  cover property (xchg_done_s ##0 skip_req);
  cover property (ram_req.we);
  cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule
`default_nettype wire

// file: tb/reg_transfer_and_ram_exchange_exec_test.sv
// self-checking bench for the exchange and transfer unit
`timescale 1ns/1ns
`default_nettype none
module reg_transfer_and_ram_exchange_exec_test
  import rtx_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  rtx_instr_t instr = '0;
  logic [1:0] file_ptr = 2'h2;
  logic [2:0] stack_ptr = 3'h6;
  logic [3:0] ram_rdata = 4'h0;
  rtx_wb_req_t wb_req = '0;
  rtx_ram_req_t ram_req;
  logic skip_req, exec_done, wb_ack_o;
  rtx_regs_t regs, want;
  logic [31:0] wb_dat_o, rd;
  int n_fail = 0;
  int n_checks = 0;
  rtx_exec dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .instr(instr), .file_ptr(file_ptr),
    .stack_ptr(stack_ptr), .ram_rdata(ram_rdata), .ram_req(ram_req), .skip_req(skip_req),
    .exec_done(exec_done), .regs(regs), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_regs(input string m);
    n_checks++;
    if (regs !== want) begin
      n_fail++;
      $display("MISMATCH %0t %s regs %h want %h", $time, m, regs, want);
    end
  endtask
  function automatic rtx_regs_t step(input rtx_regs_t r, input logic [9:0] c, input logic [3:0] d);
    if (c[9:4] == XCHG_INC_PFX) begin
      r.acc = d;
      r.col = r.col ^ c[3:0];
      r.row = r.row + 4'h1;
    end
    case (c)
      OPC_COPY_B_TO_ACC: r.acc = r.b;
      OPC_COPY_ACC_TO_B: r.b = r.acc;
      OPC_COPY_ROW_TO_ACC: r.acc = r.row;
      OPC_COPY_ACC_TO_ROW: r.row = r.acc;
      OPC_PACK_B_ACC_INTO_E: r.e = {r.b, r.acc};
      OPC_UNPACK_E_TO_B_ACC: {r.b, r.acc} = r.e;
      OPC_COPY_ACC_TO_PORT_REG: r.port_reg = r.acc[2:0];
      OPC_COPY_PORT_REG_TO_ACC: r.acc = {1'b0, r.port_reg};
      OPC_COPY_FILE_PTR_TO_ACC: r.acc = {2'b00, file_ptr};
      OPC_COPY_COL_TO_ACC: r.acc = r.col;
      OPC_COPY_STACK_PTR_TO_ACC: r.acc = {1'b0, stack_ptr};
      default: ;
    endcase
    return r;
  endfunction
  // one instruction for one cycle, then registers and pulses
  task automatic run(input logic [9:0] c, input logic [3:0] d, input logic dn, input string m);
    logic sk;
    rtx_ram_req_t rq;
    rq.addr = {file_ptr, want.col, want.row};
    rq.wdata = want.acc;
    rq.we = dn && c[9:4] == XCHG_INC_PFX;
    if (dn) begin
      want = step(want, c, d);
    end
    sk = rq.we && want.row == 4'h0;
    @(posedge ref_clk);
    instr <= '{1'b1, c};
    ram_rdata <= d;
    @(negedge ref_clk);
    chk_word({17'h0, ram_req}, {17'h0, rq}, {m, " ram"});
    @(posedge ref_clk);
    instr <= '0;
    ram_rdata <= ~d;
    @(negedge ref_clk);
    chk_regs(m);
    chk_word({30'h0, skip_req, exec_done}, {30'h0, sk, dn}, m);
  endtask
  // waits for ack with no cycle limit of its own; the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge ref_clk);
    wb_req <= '{1'b1, 1'b1, w, 4'hF, a, dt};
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_req <= '0;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  initial begin
    want = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b0, OFS_CTRL, 32'h0);
    chk_word(rd, 32'h1, "ctrl");
    run(10'h2E5, 4'h9, 1'b1, "swap");
    run(OPC_COPY_ACC_TO_B, 4'h0, 1'b1, "a2b");
    run(10'h2EF, 4'hF, 1'b1, "swap f");
    run(OPC_COPY_ACC_TO_ROW, 4'h0, 1'b1, "a2row");
    run(10'h2E0, 4'h6, 1'b1, "wrap");
    run(10'h2E3, 4'hC, 1'b1, "nowrap");
    run(OPC_PACK_B_ACC_INTO_E, 4'h0, 1'b1, "pack");
    run(OPC_COPY_ACC_TO_PORT_REG, 4'h0, 1'b1, "a2port");
    run(OPC_COPY_B_TO_ACC, 4'h0, 1'b1, "b2a");
    run(OPC_COPY_ROW_TO_ACC, 4'h0, 1'b1, "row2a");
    run(OPC_COPY_ACC_TO_B, 4'h0, 1'b1, "a2b again");
    run(OPC_UNPACK_E_TO_B_ACC, 4'h0, 1'b1, "unpack");
    run(OPC_COPY_PORT_REG_TO_ACC, 4'h0, 1'b1, "port2a");
    run(OPC_COPY_FILE_PTR_TO_ACC, 4'h0, 1'b1, "file2a");
    run(OPC_COPY_COL_TO_ACC, 4'h0, 1'b1, "col2a");
    run(OPC_COPY_STACK_PTR_TO_ACC, 4'h0, 1'b1, "sp2a");
    run(10'h2F4, 4'h1, 1'b0, "other");
    wb(1'b0, OFS_STATUS, 32'h0);
    chk_word(rd, 32'h3, "status");
    wb(1'b1, OFS_STATUS, 32'h3);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk_word(rd, 32'h0, "status clr");
    wb(1'b1, OFS_CTRL, 32'h0);
    run(10'h2E1, 4'h2, 1'b0, "disabled");
    wb(1'b1, OFS_CTRL, 32'h1);
    @(posedge ref_clk);
    ce <= 1'b0;
    run(10'h2E1, 4'h2, 1'b0, "frozen");
    @(posedge ref_clk);
    ce <= 1'b1;
    run(10'h2E7, 4'hB, 1'b1, "swap 7");
    wb(1'b0, OFS_NIBS, 32'h0);
    chk_word(rd, {16'h0, want.row, want.col, want.b, want.acc}, "nibs");
    wb(1'b0, OFS_EPORT, 32'h0);
    chk_word(rd, {21'h0, want.port_reg, want.e}, "eport");
    wb(1'b0, 8'h10, 32'h0);
    chk_word(rd, 32'h0, "unmapped");
    summarize();
  end
endmodule
bind rtx_exec rtx_exec_checker chk (.ref_clk(ref_clk), .rst(rst), .ce(ce), .instr(instr),
  .file_ptr(file_ptr), .stack_ptr(stack_ptr), .ram_rdata(ram_rdata), .ram_req(ram_req),
  .skip_req(skip_req), .exec_done(exec_done), .regs(regs), .wb_req(wb_req),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire
